/* dcf_fifo.sv */
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Mode strap sampled at master reset, held
// - Fall-through: first word appears after three ticks
// - Write enable low captures data each write tick
// - Standard: empty flag high after first write
// - Standard: almost-empty high at n+1 words
// - Standard: almost-empty low at n words
// - Standard: half-full low above half depth
// - Standard: almost-full low at depth minus m
// - Standard: full at depth, blocks writes
// - Standard: empty low after last read, blocks reads
// - Standard: empty and full flags two stages
// - Fall-through: out_valid low once word available
// - Fall-through: almost-empty at n+2, low at n+1
// - Fall-through: half-full low above half plus one
// - Fall-through: almost-full at depth plus one minus m
// - Fall-through: in_room high after depth plus one
// - Fall-through: first read from full restores room
// - Fall-through: out_valid high when empty, blocks reads
// - Fall-through: three read stages, two write stages
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH,
  parameter int WIDTH = DATA_W
) (
  // Clock and bus reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Master reset and mode strap
  input wire logic master_reset_n_in,
  input wire logic mode_select_serial_in,
  // Write side
  input wire logic wr_tick_in,
  input wire logic wr_en_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  // Read side
  input wire logic rd_tick_in,
  input wire logic rd_en_n_in,
  output logic [WIDTH-1:0] out_data_out,
  // Flags
  output logic empty_indicator_n_out,
  output logic full_indicator_n_out,
  output logic out_valid_n_out,
  output logic in_room_n_out,
  output logic almost_empty_n_out,
  output logic half_full_n_out,
  output logic almost_full_n_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 2);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);

  // Threshold shifted by one word in fall-through mode
  function automatic logic [CW-1:0] thr(input logic [CW-1:0] base,
                                        input logic fw);
    thr = base + CW'(fw);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [CW-1:0] cnt_mem;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] tot;
  logic ov;
  logic next_ov;
  dcf_mode_t mode;
  logic fall_through_mode;
  logic mrst;
  logic [AW-1:0] n_ofs;
  logic [AW-1:0] m_ofs;
  logic mem_full;
  logic mem_empty;
  logic wr_acc;
  logic rd_acc;
  logic pop;
  logic [WIDTH-1:0] rd_word;
  dcf_level_t lvl;
  dcf_level_t next_lvl;
  logic empty_q;
  logic full_q;
  logic ov_q;
  logic ir_q;
  logic bus_done;
  logic [31:0] next_prdata;
  logic next_err;

  assign mrst = !master_reset_n_in;
  assign fall_through_mode = (mode == DCF_FALL_THROUGH);
  assign mem_full = (cnt_mem == DEPTH_C);
  assign mem_empty = (cnt_mem == '0);
  assign rd_word = mem[rp];
  assign tot = cnt_mem + CW'(fall_through_mode & ov);

  // Mode strap is caught while master reset is held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode <= DCF_STANDARD;
    end else if (mrst) begin
      mode <= mode_select_serial_in ? DCF_FALL_THROUGH
                                    : DCF_STANDARD;
    end
  end

  // Full memory refuses the write
  assign wr_acc = wr_tick_in && !wr_en_n_in && !mem_full && !mrst;

  // Read acceptance and memory pop per mode
  always_comb begin
    rd_acc = 1'b0;
    pop = 1'b0;
    next_ov = ov;
    if (!mrst && rd_tick_in) begin
      if (!fall_through_mode) begin
        rd_acc = !rd_en_n_in && !mem_empty;
        pop = rd_acc;
      end else begin
        rd_acc = !rd_en_n_in && ov && !ov_q;
        pop = !mem_empty && (!ov || rd_acc);
        if (pop) begin
          next_ov = 1'b1;
        end else if (rd_acc) begin
          next_ov = 1'b0;
        end
      end
    end
  end

  assign next_cnt = cnt_mem + CW'(wr_acc) - CW'(pop);

  // Storage array
  always_ff @(posedge clk_in) begin
    if (wr_acc) begin
      mem[wp] <= in_data_in;
    end
  end

  // Pointers, count and output-register occupancy
  always_ff @(posedge clk_in) begin
    if (rst_in || mrst) begin
      wp <= '0;
      rp <= '0;
      cnt_mem <= '0;
      ov <= 1'b0;
    end else begin
      if (wr_acc) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt_mem <= next_cnt;
      ov <= next_ov;
    end
  end

  // Output data register
  always_ff @(posedge clk_in) begin
    if (rst_in || mrst) begin
      out_data_out <= '0;
    end else if (pop) begin
      out_data_out <= rd_word;
    end
  end

  // Level flags from the combined count
  always_comb begin
    next_lvl.ae_n = (tot > thr(CW'(n_ofs), fall_through_mode));
    next_lvl.hf_n = !(tot > thr(HALF_C, fall_through_mode));
    next_lvl.af_n = !(tot >= thr(DEPTH_C - CW'(m_ofs), fall_through_mode));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || mrst) begin
      lvl <= '{ae_n: 1'b0, hf_n: 1'b1, af_n: 1'b1};
    end else begin
      lvl <= next_lvl;
    end
  end

  assign almost_empty_n_out = lvl.ae_n;
  assign half_full_n_out = lvl.hf_n;
  assign almost_full_n_out = lvl.af_n;

  // Boundary flags, staged in their own tick domains
  dcf_flag_stages #(.STAGES(STD_FLAG_STAGES), .RST_VAL(1'b0)) u_empty (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(mrst),
    .tick_in(rd_tick_in),
    .d_in(!fall_through_mode && (next_cnt != '0)),
    .q_out(empty_q)
  );

  dcf_flag_stages #(.STAGES(STD_FLAG_STAGES), .RST_VAL(1'b1)) u_full (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(mrst),
    .tick_in(wr_tick_in),
    .d_in(fall_through_mode || (next_cnt != DEPTH_C)),
    .q_out(full_q)
  );

  dcf_flag_stages #(.STAGES(OUT_VALID_STAGES), .RST_VAL(1'b1)) u_ov (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(mrst),
    .tick_in(rd_tick_in),
    .d_in(!(fall_through_mode && next_ov)),
    .q_out(ov_q)
  );

  dcf_flag_stages #(.STAGES(IN_ROOM_STAGES), .RST_VAL(1'b0)) u_ir (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(mrst),
    .tick_in(wr_tick_in),
    .d_in(!fall_through_mode || ((next_cnt == DEPTH_C) && next_ov)),
    .q_out(ir_q)
  );

  assign empty_indicator_n_out = empty_q;
  assign full_indicator_n_out = full_q;
  assign out_valid_n_out = ov_q;
  assign in_room_n_out = ir_q;

  // APB: one wait-free access phase, pready raised from setup
  assign bus_done = psel_in && penable_in && pready_out;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    unique case (paddr_in)
      EMPTY_OFS_ADDR: next_prdata[AW-1:0] = n_ofs;
      FULL_OFS_ADDR: next_prdata[AW-1:0] = m_ofs;
      STATUS_ADDR: begin
        next_prdata[ST_MODE_BIT] = fall_through_mode;
        next_prdata[ST_EMPTY_BIT] = empty_q;
        next_prdata[ST_FULL_BIT] = full_q;
        next_prdata[ST_AE_BIT] = lvl.ae_n;
        next_prdata[ST_HF_BIT] = lvl.hf_n;
        next_prdata[ST_AF_BIT] = lvl.af_n;
        next_prdata[ST_OV_BIT] = ov_q;
        next_prdata[ST_IR_BIT] = ir_q;
      end
      COUNT_ADDR: next_prdata[CW-1:0] = tot;
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && next_err;
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= next_prdata;
      end
    end
  end

  // Offset registers, width limits them to depth-1
  always_ff @(posedge clk_in) begin
    if (rst_in || mrst) begin
      n_ofs <= AW'(DEF_OFS);
      m_ofs <= AW'(DEF_OFS);
    end else if (bus_done && pwrite_in) begin
      if (paddr_in == EMPTY_OFS_ADDR) begin
        n_ofs <= pwdata_in[AW-1:0];
      end
      if (paddr_in == FULL_OFS_ADDR) begin
        m_ofs <= pwdata_in[AW-1:0];
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in || mrst);

  a_mode_held_run: assert property (
    !$past(mrst) |-> $stable(mode))
    else $error("mode changed outside master reset");

  a_full_blocks_wr: assert property (
    mem_full && wr_tick_in && !wr_en_n_in |=> $stable(wp))
    else $error("write accepted while full");

  a_std_empty_rd: assert property (
    !fall_through_mode && mem_empty && rd_tick_in |=> $stable(rp))
    else $error("read accepted while empty");

  a_std_ae_level: assert property (
    !fall_through_mode ##1 !fall_through_mode |-> almost_empty_n_out ==
      ($past(tot) > CW'($past(n_ofs))))
    else $error("almost-empty level wrong in standard mode");

  a_fall_through_mode_hf_level: assert property (
    fall_through_mode ##1 fall_through_mode |-> half_full_n_out == ($past(tot) <= HALF_C + 1'b1))
    else $error("half-full level wrong in fall-through mode");

  a_std_af_level: assert property (
    !fall_through_mode ##1 !fall_through_mode |-> almost_full_n_out ==
      ($past(tot) < DEPTH_C - CW'($past(m_ofs))))
    else $error("almost-full level wrong in standard mode");

  a_fall_through_mode_first_load: assert property (
    fall_through_mode && !ov && !mem_empty && rd_tick_in
      |=> ov && out_data_out == $past(rd_word))
    else $error("first word did not fall through");

  a_write_count: assert property (
    1'b1 |=> cnt_mem == $past(cnt_mem) + CW'($past(wr_acc))
      - CW'($past(pop)))
    else $error("stored count out of step");

  a_fall_through_mode_rd_ignored: assert property (
    fall_through_mode && !ov && rd_tick_in && !rd_en_n_in && mem_empty
      |=> !ov && $stable(out_data_out))
    else $error("read taken with no word in output register");

endmodule // dcf_fifo

/* dcf_pkg.sv */
package dcf_pkg;

  // Data path and default depth
  localparam int DATA_W = 36;
  localparam int DEF_DEPTH = 1024;

  // APB register byte addresses
  localparam logic [11:0] EMPTY_OFS_ADDR = 12'h000;
  localparam logic [11:0] FULL_OFS_ADDR = 12'h004;
  localparam logic [11:0] STATUS_ADDR = 12'h008;
  localparam logic [11:0] COUNT_ADDR = 12'h00c;

  // Offset value loaded at master reset
  localparam logic [15:0] DEF_OFS = 16'h007f;

  // Register stages on the boundary flags
  localparam int STD_FLAG_STAGES = 2;
  localparam int OUT_VALID_STAGES = 3;
  localparam int IN_ROOM_STAGES = 2;

  // Status register bit positions
  localparam int ST_MODE_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_AE_BIT = 3;
  localparam int ST_HF_BIT = 4;
  localparam int ST_AF_BIT = 5;
  localparam int ST_OV_BIT = 6;
  localparam int ST_IR_BIT = 7;

  typedef enum logic {DCF_STANDARD, DCF_FALL_THROUGH} dcf_mode_t;

  // Level flags, all active low
  typedef struct packed {
    logic ae_n;
    logic hf_n;
    logic af_n;
  } dcf_level_t;

endpackage

/* dcf_flag_stages.sv */
`timescale 1ns/100ps
module dcf_flag_stages #(
  parameter int STAGES = 2,
  parameter logic RST_VAL = 1'b1
) (
  // Clock and resets
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  // Stage advance and flag
  input wire logic tick_in,
  input wire logic d_in,
  output logic q_out
);

  logic [STAGES-1:0] pipe;

  // Shift only on the owning side's clock tick
  always_ff @(posedge clk_in) begin
    if (rst_in || clr_in) begin
      pipe <= {STAGES{RST_VAL}};
    end else if (tick_in) begin
      pipe <= {pipe[STAGES-2:0], d_in};
    end
  end

  assign q_out = pipe[STAGES-1];

endmodule // dcf_flag_stages

/* dcf_peer_model.sv */
`timescale 1ns/100ps
module dcf_peer
  import dcf_pkg::*;
(
  // Clock, reset and pacing
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  // Requests from the bench
  input wire logic wr_req_in,
  input wire logic rd_req_in,
  // Writer side
  output logic wr_tick_out,
  output logic wr_en_n_out,
  output logic [DATA_W-1:0] in_data_out,
  // Reader side
  output logic rd_tick_out,
  output logic rd_en_n_out
);
  logic [DATA_W-1:0] seq;
  assign wr_en_n_out = ~wr_req_in;
  assign rd_en_n_out = ~rd_req_in;
  // Idle data lines show the inverse so a stale word is never captured
  assign in_data_out = wr_en_n_out ? ~seq : seq;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_tick_out <= 1'b0;
      rd_tick_out <= 1'b0;
    end else begin
      wr_tick_out <= !slow_in || !wr_tick_out;
      rd_tick_out <= !slow_in || !rd_tick_out;
    end
  end
  // Each offered word is the number of words offered before it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq <= '0;
    end else if (wr_tick_out && !wr_en_n_out) begin
      seq <= seq + 1'b1;
    end
  end
endmodule // dcf_peer

/* dcf_fifo_tb.sv */
`timescale 1ns/100ps
module dcf_fifo_tb;
  import dcf_pkg::*;
  localparam int D = 1024;
  localparam int N = 4;
  localparam int M = 8;
  logic clk_in = 0, rst_in = 1, mrst_n = 0, mode = 0, slow = 0;
  logic wr_req = 0, rd_req = 0, wr_tick, wr_en_n, rd_tick, rd_en_n;
  logic [DATA_W-1:0] din, dout, wexp = 0, rexp = 0;
  logic ef_n, ff_n, ov_n, ir_n, ae_n, hf_n, af_n;
  logic psel = 0, pen = 0, pwr = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int fails = 0, num_checks = 0, cyc = 0, cur = 0;

  always #25 clk_in = ~clk_in;

  dcf_fifo #(.DEPTH(D)) u_dcf_fifo (.clk_in(clk_in), .rst_in(rst_in),
    .master_reset_n_in(mrst_n), .mode_select_serial_in(mode),
    .wr_tick_in(wr_tick), .wr_en_n_in(wr_en_n), .in_data_in(din),
    .rd_tick_in(rd_tick), .rd_en_n_in(rd_en_n), .out_data_out(dout),
    .empty_indicator_n_out(ef_n), .full_indicator_n_out(ff_n),
    .out_valid_n_out(ov_n), .in_room_n_out(ir_n),
    .almost_empty_n_out(ae_n), .half_full_n_out(hf_n),
    .almost_full_n_out(af_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  dcf_peer u_dcf_peer (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
    .wr_req_in(wr_req), .rd_req_in(rd_req), .wr_tick_out(wr_tick),
    .wr_en_n_out(wr_en_n), .in_data_out(din), .rd_tick_out(rd_tick),
    .rd_en_n_out(rd_en_n));

  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic ce(logic [DATA_W-1:0] s, logic [DATA_W-1:0] e, string m);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic put(int k);
    wr_req <= 1'b1;
    repeat (k) begin
      do @(posedge clk_in); while (wr_tick !== 1'b1);
    end
    wr_req <= 1'b0;
    wexp += DATA_W'(k);
    @(posedge clk_in);
  endtask

  // Request drops at the edge that takes the last read
  task automatic get(int k, logic ft);
    rd_req <= 1'b1;
    for (int j = 1; j <= k; j++) begin
      do @(posedge clk_in); while (rd_tick !== 1'b1);
      if (j == k) rd_req <= 1'b0;
      if (ft) ce(dout, rexp, "ft word");
      @(negedge clk_in);
      if (!ft) ce(dout, rexp, "std word");
      rexp += 1'b1;
    end
    @(posedge clk_in);
  endtask

  // Flags settle within the staged ticks, then match the word count
  task automatic chk(logic ft, int c);
    repeat (10) @(posedge clk_in);
    ce(ae_n, c > N + ft, "ae");
    ce(hf_n, c <= D / 2 + ft, "hf");
    ce(af_n, c < D + ft - M, "af");
    ce(ef_n, !ft && c != 0, "ef");
    ce(ff_n, ft || c != D, "ff");
    ce(ov_n, !ft || c == 0, "ov");
    ce(ir_n, !ft || c == D + 1, "ir");
    apb(1'b0, COUNT_ADDR, '0);
    ce(rd, c, "count");
  endtask

  task automatic walk(logic ft, int t[8], logic up);
    foreach (t[i]) begin
      if (up && t[i] > cur) put(t[i] - cur);
      if (!up && t[i] < cur) get(cur - t[i], ft);
      chk(ft, t[i]);
      cur = t[i];
    end
  endtask

  // Strap changes after release must not move the mode
  task automatic mreset(logic ft);
    mrst_n <= 1'b0;
    mode <= ft;
    repeat (2) @(posedge clk_in);
    mrst_n <= 1'b1;
    @(posedge clk_in);
    mode <= !ft;
    apb(1'b1, EMPTY_OFS_ADDR, N);
    apb(1'b1, FULL_OFS_ADDR, M);
    apb(1'b0, STATUS_ADDR, '0);
    ce(rd[ST_MODE_BIT], ft, "mode");
    cur = 0;
    rexp = wexp;
  endtask

  task automatic sc_apb();
    apb(1'b1, 12'h010, 32'h0000_00a5);
    ce(err, 1'b1, "unmapped wr");
    apb(1'b0, 12'h010, '0);
    ce({err, rd}, 33'h1_0000_0000, "unmapped rd");
    apb(1'b1, FULL_OFS_ADDR, 32'h0000_fc08);
    apb(1'b0, FULL_OFS_ADDR, '0);
    ce(rd, 32'h0000_0008, "trunc");
    apb(1'b0, EMPTY_OFS_ADDR, '0);
    ce(rd, DEF_OFS, "default ofs");
  endtask

  task automatic sc_std();
    mreset(1'b0);
    walk(1'b0, '{1, 4, 5, 512, 513, 1015, 1016, 1024}, 1'b1);
    put(1);
    chk(1'b0, D);
    walk(1'b0, '{1023, 1016, 1015, 513, 512, 5, 4, 0}, 1'b0);
    rd_req <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_req <= 1'b0;
    ce(dout, rexp - 1'b1, "empty read");
    chk(1'b0, 0);
  endtask

  task automatic sc_ft();
    mreset(1'b1);
    wr_req <= 1'b1;
    do @(posedge clk_in); while (wr_tick !== 1'b1);
    wr_req <= 1'b0;
    wexp += 1'b1;
    repeat (2) do @(posedge clk_in); while (rd_tick !== 1'b1);
    @(negedge clk_in);
    ce(ov_n, 1'b1, "ov early");
    do @(posedge clk_in); while (rd_tick !== 1'b1);
    @(negedge clk_in);
    ce(ov_n, 1'b0, "ov late");
    ce(dout, rexp, "first word");
    @(posedge clk_in);
    cur = 1;
    walk(1'b1, '{1, 5, 6, 513, 514, 1016, 1017, 1025}, 1'b1);
    put(1);
    chk(1'b1, D + 1);
    slow <= 1'b1;
    walk(1'b1, '{1024, 1017, 1016, 514, 513, 6, 5, 0}, 1'b0);
    rd_req <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd_req <= 1'b0;
    ce(dout, rexp - 1'b1, "ft empty read");
    chk(1'b1, 0);
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    mrst_n <= 1'b1;
    @(posedge clk_in);
    sc_apb();
    sc_std();
    sc_ft();
    tally_and_finish();
  end
endmodule // dcf_fifo_tb
